// ==== inc/asr_pkg.sv ====
// constants and carriers for the addressable shift cell
// =====================================================================
// Overview of operation
// - shifts on one selectable clock edge, default rising
// - no enable: no bit accepted, nothing moves
// - enable: input to stage zero, rest move on
// - tap output shows stage picked by select
// - chain output always from stage thirty-one
// - chain output updates after every enabled shift
// - global set/reset leaves stored contents alone
// - one bit in, two bits out: tap and chain
// - tap delay equals select value plus one
// - chain output feeds next segment serial input
package asr_pkg;

  // =====================================================================
  // geometry
  localparam int unsigned STAGE_COUNT = 32;
  localparam int unsigned SEL_WIDTH = 5;
  localparam int unsigned LAST_STAGE = 31;
  localparam int unsigned FILL_WIDTH = 6;
  localparam logic [5:0] FILL_FULL = 6'h20;
  localparam logic [5:0] FILL_RESET = 6'h00;

  // =====================================================================
  // carriers
  typedef logic [STAGE_COUNT-1:0] asr_stages_t;

  typedef struct packed {
    logic shift_en;
    logic serial_in;
    logic [SEL_WIDTH-1:0] tap_sel;
  } asr_ctrl_t;

  typedef struct packed {
    logic tap_out;
    logic chain_out;
    logic tap_valid;
  } asr_result_t;

endpackage

// ==== rtl/asr_addressable_shift_cell.sv ====
// 32-stage addressable shift cell with chain output
`timescale 1ns/1ns
module asr_addressable_shift_cell #(
  parameter bit CLK_INVERTED = 1'b0
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic global_set_reset,
  input wire asr_pkg::asr_ctrl_t ctrl,
  output asr_pkg::asr_result_t result
);

  // =====================================================================
  // clock edge choice
  // xor folds into the clock inverter, no extra logic
  logic active_clk;
  assign active_clk = core_clk ^ CLK_INVERTED;

  // =====================================================================
  // storage
  // no reset here: neither resetn nor global set/reset touch contents
  asr_pkg::asr_stages_t stage_reg;
  asr_pkg::asr_stages_t stage_next;

  always_comb begin
    stage_next = stage_reg;
    if (ctrl.shift_en) begin
      stage_next = {stage_reg[asr_pkg::LAST_STAGE-1:0], ctrl.serial_in};
    end
  end

  always_ff @(posedge active_clk) begin
    stage_reg <= stage_next;
  end

  // =====================================================================
  // fill tracking
  // only bookkeeping resets; stored bits stay unknown until shifted in
  logic [asr_pkg::FILL_WIDTH-1:0] fill_reg;
  logic [asr_pkg::FILL_WIDTH-1:0] fill_next;

  always_comb begin
    fill_next = fill_reg;
    if (!resetn) begin
      fill_next = asr_pkg::FILL_RESET;
    end else if (ctrl.shift_en && fill_reg != asr_pkg::FILL_FULL) begin
      fill_next = fill_reg + 6'h01;
    end
  end

  always_ff @(posedge active_clk) begin
    fill_reg <= fill_next;
  end

  // stages hold no unknown bits once 32 shifts have passed since reset
  logic stages_known;
  assign stages_known = (fill_reg == asr_pkg::FILL_FULL);

  // =====================================================================
  // outputs
  logic tap_bit;

  asr_tap_mux u_tap_mux (
    .stages(stage_reg),
    .tap_sel(ctrl.tap_sel),
    .tap_out(tap_bit)
  );

  always_comb begin
    result.tap_out = tap_bit;
    result.chain_out = stage_reg[asr_pkg::LAST_STAGE];
    result.tap_valid = fill_reg > {1'b0, ctrl.tap_sel};
  end

  // =====================================================================
  // checks
  sequence s_shift_once;
    ctrl.shift_en;
  endsequence

  sequence s_shift_three;
    ctrl.shift_en [*3];
  endsequence

  AST_HOLD: assert property (
    @(posedge active_clk) disable iff (!resetn)
    !ctrl.shift_en && stages_known |=> stage_reg == $past(stage_reg)
  ) else $error("stages moved without shift enable");

  AST_SHIFT_IN: assert property (
    @(posedge active_clk) disable iff (!resetn)
    s_shift_once |=> stage_reg[0] == $past(ctrl.serial_in)
  ) else $error("serial input not captured in stage zero");

  AST_MOVE: assert property (
    @(posedge active_clk) disable iff (!resetn)
    s_shift_once and stages_known
      |=> stage_reg[31:1] == $past(stage_reg[30:0])
  ) else $error("stages did not move by one");

  AST_TAP_PICK: assert property (
    @(posedge active_clk) disable iff (!resetn)
    result.tap_valid |-> result.tap_out == stage_reg[ctrl.tap_sel]
  ) else $error("tap output not the selected stage");

  AST_CHAIN_LAST: assert property (
    @(posedge active_clk) disable iff (!resetn)
    stages_known |-> result.chain_out == stage_reg[asr_pkg::LAST_STAGE]
  ) else $error("chain output not the last stage");

  AST_CHAIN_UPDATE: assert property (
    @(posedge active_clk) disable iff (!resetn)
    s_shift_once and stages_known
      |=> result.chain_out == $past(stage_reg[30])
  ) else $error("chain output missed the shifted bit");

  AST_GSR_KEEP: assert property (
    @(posedge active_clk) disable iff (!resetn)
    global_set_reset && !ctrl.shift_en && stages_known
      |=> $stable(stage_reg)
  ) else $error("global set reset disturbed contents");

  AST_DELAY_ONE: assert property (
    @(posedge active_clk) disable iff (!resetn)
    s_shift_once ##1 (ctrl.tap_sel == 5'h00)
      |-> result.tap_out == $past(ctrl.serial_in)
  ) else $error("select zero is not a one stage delay");

  AST_DELAY_THREE: assert property (
    @(posedge active_clk) disable iff (!resetn)
    s_shift_three ##1 (ctrl.tap_sel == 5'h02)
      |-> result.tap_out == $past(ctrl.serial_in, 3)
  ) else $error("select two is not a three stage delay");

  AST_FILL_RESET: assert property (
    @(posedge active_clk)
    !resetn |=> fill_reg == asr_pkg::FILL_RESET && !result.tap_valid
  ) else $error("fill count not cleared by reset");

endmodule

// ==== rtl/asr_tap_mux.sv ====
// read tap multiplexer of the addressable shift cell
`timescale 1ns/1ns
module asr_tap_mux (
  input wire asr_pkg::asr_stages_t stages,
  input wire logic [asr_pkg::SEL_WIDTH-1:0] tap_sel,
  output logic tap_out
);

  // =====================================================================
  // stage pick
  function automatic logic pick_stage(
    input asr_pkg::asr_stages_t s,
    input logic [asr_pkg::SEL_WIDTH-1:0] sel
  );
    pick_stage = s[sel];
  endfunction

  // unregistered on purpose: select changes show at once
  always_comb begin
    tap_out = pick_stage(stages, tap_sel);
  end

endmodule

// ==== testbench/asr_user_fabric.sv ====
// user-side logic that registers the tap output
`timescale 1ns/1ns
module asr_user_fabric (
  input wire logic core_clk,
  input wire logic tap_out,
  output logic tap_sync_reg
);
  // ==========
  // synchronous read
  // same clock as the cell, so select is length minus two
  always_ff @(posedge core_clk) begin
    tap_sync_reg <= tap_out;
  end
endmodule

// ==== testbench/test_addressable_shift_register32.sv ====
// self-checking bench for the addressable shift cell
`timescale 1ns/1ns
module test_addressable_shift_register32;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic global_set_reset = 1'b0;
  asr_pkg::asr_ctrl_t ctrl = '0;
  asr_pkg::asr_result_t result;
  logic tap_sync;
  asr_pkg::asr_stages_t exp_reg;
  localparam logic [31:0] FILL_WORD = 32'h9c3a_51e7;
  int mismatches = 0;
  int checks = 0;

  always #2 core_clk = ~core_clk;

  asr_addressable_shift_cell dut_u (.core_clk(core_clk), .resetn(resetn),
    .global_set_reset(global_set_reset), .ctrl(ctrl), .result(result));
  asr_user_fabric fab_u (.core_clk(core_clk), .tap_out(result.tap_out),
    .tap_sync_reg(tap_sync));

  // ==========
  // helpers
  task automatic chk(input string what, input logic e, input logic s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", what, e, s);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // called at a falling edge, returns at the next one
  task automatic shift(input logic b, input logic en);
    ctrl.shift_en = en;
    ctrl.serial_in = b;
    @(negedge core_clk);
    if (en)
      exp_reg = {exp_reg[30:0], b};
  endtask

  // ==========
  // scenarios
  task automatic scan_taps();
    ctrl.shift_en = 1'b0;
    for (int i = 0; i < 32; i++) begin
      ctrl.tap_sel = i[4:0];
      #1;
      chk("tap_out", exp_reg[i], result.tap_out);
      chk("tap_valid", 1'b1, result.tap_valid);
      chk("chain_out", exp_reg[31], result.chain_out);
      @(negedge core_clk);
      chk("tap_sync", exp_reg[i], tap_sync);
    end
  endtask

  task automatic fill_and_scan();
    for (int i = 0; i < 32; i++)
      shift(FILL_WORD[i], 1'b1);
    scan_taps();
  endtask

  task automatic back_to_back();
    ctrl.tap_sel = 5'h03;
    for (int k = 0; k < 4; k++) begin
      shift(k[0], 1'b1);
      chk("chain_out", exp_reg[31], result.chain_out);
      chk("tap_out", exp_reg[3], result.tap_out);
    end
  endtask

  // fixed length eight: select tied to 0b00111
  task automatic static_tap();
    ctrl.tap_sel = 5'h07;
    for (int k = 0; k < 8; k++) begin
      shift(k[1], 1'b1);
      chk("tap_out", exp_reg[7], result.tap_out);
    end
  endtask

  // enable low with toggling data and global set/reset held
  task automatic hold_and_gsr();
    global_set_reset = 1'b1;
    for (int k = 0; k < 8; k++)
      shift(~k[0], 1'b0);
    scan_taps();
    global_set_reset = 1'b0;
  endtask

  // reset clears the fill count only, contents survive
  task automatic reset_keeps_data();
    ctrl.shift_en = 1'b0;
    resetn = 1'b0;
    @(negedge core_clk);
    resetn = 1'b1;
    ctrl.tap_sel = 5'h00;
    #1;
    chk("tap_valid", 1'b0, result.tap_valid);
    chk("tap_out", exp_reg[0], result.tap_out);
    @(negedge core_clk);
    shift(1'b1, 1'b1);
    #1;
    chk("tap_valid", 1'b1, result.tap_valid);
    ctrl.tap_sel = 5'h01;
    #1;
    chk("tap_valid", 1'b0, result.tap_valid);
  endtask

  initial begin
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    fill_and_scan();
    back_to_back();
    static_tap();
    hold_and_gsr();
    reset_keeps_data();
    end_of_test();
  end

  // watchdog against a hang
  initial begin
    #100000;
    mismatches++;
    end_of_test();
  end
endmodule
